// ==== src/wcs_pkg.sv ====
// Constants and types shared by the waveform capture sequencer.
// Assumes a 10 MHz sequencer clock; all panel inputs are synchronous to it.
package wcs_pkg;
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 11;
  localparam int MEM_DEPTH  = 2048;
  localparam int NUM_RATES  = 16;
  localparam int FAST_RATES = 6;
  localparam int RATE_W     = 4;
  localparam int HOLD_W     = 5;
  localparam int TMR_W      = 32;
  localparam int REM_AW     = 13;
  localparam int REM_STAT_BIT = 12;
  localparam int REM_MEM_BIT  = 11;

  localparam logic [ADDR_W-1:0] MARK_MIN  = 11'h002;
  localparam logic [ADDR_W-1:0] MARK_MAX  = 11'h7D0;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 11'h7FF;
  localparam logic [ADDR_W:0]   WORDS     = 12'h800;
  localparam logic [ADDR_W:0]   LEFT_ONE  = 12'h001;

  // Sampling period of each rate setting, in microseconds per word
  localparam int RATE_US [NUM_RATES] = '{1, 2, 5, 10, 20, 50, 100, 200, 500,
                                         1000, 2000, 5000, 10000, 20000, 50000, 100000};
  // Recorder word period per speed setting, in milliseconds
  localparam int PEN_MS [3] = '{10, 20, 50};

  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_US     = 1000;
  localparam int US_PER_MS     = 1000;
  localparam int MS_PER_S      = 1000;
  localparam int PREP_MS       = 2000;
  localparam int REPEAT_MS     = 500;
  localparam int STEP_MS       = 20;

  typedef enum logic [2:0] {
    VSEL_CH1  = 3'h0,
    VSEL_CH2  = 3'h1,
    VSEL_DUAL = 3'h2,
    VSEL_ADD  = 3'h3,
    VSEL_XY   = 3'h4
  } vsel_e;

  typedef enum logic [2:0] {
    ST_READ,
    ST_FREE,
    ST_WRITE,
    ST_HOLDOFF,
    ST_PREP,
    ST_PEN
  } seq_e;
endpackage : wcs_pkg

// ==== src/waveform_capture_sequencer.sv ====
// Capture sequencer: two sample memories, marker, recorder readout.
// Assumes panel levels and pulses synchronous to i_ref_clk.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module waveform_capture_sequencer #(
  parameter int CYC_PER_US    = wcs_pkg::NS_PER_US / wcs_pkg::CLK_PERIOD_NS,
  parameter int CYC_PER_MS    = CYC_PER_US * wcs_pkg::US_PER_MS,
  parameter int PREP_CYCLES   = wcs_pkg::PREP_MS * CYC_PER_MS,
  parameter int SEC_CYCLES    = wcs_pkg::MS_PER_S * CYC_PER_MS,
  parameter int REPEAT_CYCLES = wcs_pkg::REPEAT_MS * CYC_PER_MS,
  parameter int STEP_CYCLES   = wcs_pkg::STEP_MS * CYC_PER_MS
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_arst_n,
  input  wire logic [wcs_pkg::DATA_W-1:0]    i_first_input,
  input  wire logic [wcs_pkg::DATA_W-1:0]    i_second_input,
  input  wire logic                          i_trigger,
  input  wire logic                          i_start,
  input  wire logic                          i_early_capture,
  input  wire logic                          i_split_channel,
  input  wire logic [2:0]                    i_trace_sel,
  input  wire logic [wcs_pkg::RATE_W-1:0]    i_rate_a,
  input  wire logic [wcs_pkg::RATE_W-1:0]    i_rate_b,
  input  wire logic                          i_ext_read_sel,
  input  wire logic                          i_external_read_clock,
  input  wire logic                          i_remote_sel,
  input  wire logic [1:0]                    i_hold_memory,
  input  wire logic                          i_marker_left,
  input  wire logic                          i_marker_right,
  input  wire logic                          i_recorder_mode,
  input  wire logic                          i_auto_repeat,
  input  wire logic [1:0]                    i_pen_speed,
  input  wire logic                          i_hold_time_en,
  input  wire logic [wcs_pkg::HOLD_W-1:0]    i_hold_secs,
  input  wire logic [wcs_pkg::REM_AW-1:0]    i_addr,
  input  wire logic [wcs_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [wcs_pkg::DATA_W-1:0]    o_rdata,
  output logic      [1:0]                    o_write_led,
  output logic                               o_read_led,
  output logic                               o_hold_led,
  output logic      [wcs_pkg::ADDR_W-1:0]    o_marker,
  output logic      [1:0]                    o_marker_show,
  output logic      [wcs_pkg::ADDR_W-1:0]    o_disp_addr,
  output logic      [wcs_pkg::DATA_W-1:0]    o_disp_first,
  output logic      [wcs_pkg::DATA_W-1:0]    o_disp_second,
  output logic                               o_disp_valid,
  output logic      [wcs_pkg::DATA_W-1:0]    o_rec_first,
  output logic      [wcs_pkg::DATA_W-1:0]    o_rec_second,
  output logic                               o_rec_active
);
  import wcs_pkg::*;

  typedef struct packed {
    seq_e                                   state;
    logic [1:0][MEM_DEPTH-1:0][DATA_W-1:0]  mem;
    logic [1:0]                             wr_on;
    logic [1:0]                             wr_free;
    logic [1:0][ADDR_W-1:0]                 wr_addr;
    logic [1:0][ADDR_W:0]                   wr_left;
    logic [1:0][TMR_W-1:0]                  tmr;
    logic                                   other_pend;
    logic [TMR_W-1:0]                       gtmr;
    logic [HOLD_W-1:0]                      secs;
    logic [ADDR_W-1:0]                      pen_addr;
    logic [ADDR_W-1:0]                      marker;
    logic [TMR_W-1:0]                       btn_tmr;
    logic [1:0]                             btn_prev;
    logic                                   ext_prev;
    logic [ADDR_W-1:0]                      disp_ptr;
    logic [ADDR_W-1:0]                      disp_addr;
    logic [DATA_W-1:0]                      disp_first;
    logic [DATA_W-1:0]                      disp_second;
    logic                                   disp_valid;
    logic [DATA_W-1:0]                      rec_first;
    logic [DATA_W-1:0]                      rec_second;
    logic                                   rec_active;
    logic [DATA_W-1:0]                      rdata;
    logic [1:0]                             led_write;
    logic                                   led_read;
    logic                                   led_hold;
    logic [1:0]                             mark_show;
  } st_s;

  st_s                     st;
  st_s                     next_st;
  logic [1:0][TMR_W-1:0]   per;
  logic [1:0]              tick;
  logic [1:0]              fast;
  logic [1:0]              blk;
  logic [1:0][DATA_W-1:0]  src;
  logic [DATA_W-1:0]       src_main;
  logic                    m;
  logic                    o;
  logic                    split_now;
  logic                    dual;
  logic                    xy;
  logic                    can_wr;
  logic                    go_ss;
  logic                    go_pt;
  logic                    pen_go;
  logic                    step;
  logic [TMR_W-1:0]        pen_per;
  logic [1:0]              pen_idx;

  assign dual      = (i_trace_sel == VSEL_DUAL);
  assign xy        = (i_trace_sel == VSEL_XY);
  assign m         = (i_trace_sel == VSEL_CH2) || (i_trace_sel == VSEL_ADD);
  assign o         = ~m;
  // Two-trace single-shot falls back to direct; XY never splits
  assign split_now = i_split_channel && !xy && (i_early_capture || !dual);
  assign src_main  = (i_trace_sel == VSEL_ADD) ? DATA_W'(i_first_input + i_second_input)
                   : (m ? i_second_input : i_first_input);
  assign pen_idx   = (i_pen_speed > 2'h2) ? 2'h2 : i_pen_speed;
  assign pen_per   = TMR_W'(PEN_MS[pen_idx] * CYC_PER_MS);

  assign can_wr = !i_ext_read_sel && !(i_recorder_mode && !i_auto_repeat);
  assign go_ss  = can_wr && (!i_early_capture || i_auto_repeat)
                && (i_trigger || (i_start && !i_auto_repeat));
  assign go_pt  = can_wr && i_early_capture && !i_auto_repeat && i_start;
  assign pen_go = i_recorder_mode && !i_auto_repeat && i_start;

  // Per-channel sample clock, data source and write blocking
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [RATE_W-1:0] rate;
    assign rate    = (c == 0) ? i_rate_a : i_rate_b;
    assign per[c]  = TMR_W'(RATE_US[rate] * CYC_PER_US);
    assign tick[c] = (st.tmr[c] >= per[c] - TMR_W'(1));
    assign fast[c] = (int'(rate) < FAST_RATES);
    assign blk[c]  = i_hold_memory[c] || i_ext_read_sel;
    assign src[c]  = ((c == int'(m)) || split_now) ? src_main
                   : ((c == 0) ? i_first_input : i_second_input);
  end

  always_comb begin
    next_st = st;
    step    = 1'b0;

    // Sample writers
    for (int c = 0; c < 2; c++) begin
      next_st.tmr[c] = tick[c] ? '0 : st.tmr[c] + TMR_W'(1);
      if (st.wr_on[c] && tick[c]) begin
        if (!blk[c]) begin
          next_st.mem[c][st.wr_addr[c]] = src[c];
        end
        next_st.wr_addr[c] = st.wr_addr[c] + 1'b1;
        if (!st.wr_free[c]) begin
          next_st.wr_left[c] = st.wr_left[c] - 1'b1;
          if (st.wr_left[c] == LEFT_ONE) begin
            next_st.wr_on[c] = 1'b0;
          end
        end
      end
    end

    unique case (st.state)
      ST_READ: begin
        if (go_ss || go_pt) begin
          for (int c = 0; c < 2; c++) begin
            if ((c == int'(m)) || !split_now) begin
              next_st.wr_on[c]   = 1'b1;
              next_st.wr_free[c] = go_pt;
              next_st.wr_addr[c] = '0;
              next_st.wr_left[c] = WORDS;
              next_st.tmr[c]     = '0;
            end
          end
          next_st.other_pend = split_now && go_ss;
          next_st.state      = go_pt ? ST_FREE : ST_WRITE;
        end else if (pen_go) begin
          next_st.gtmr  = '0;
          next_st.state = ST_PREP;
        end
      end
      ST_FREE: begin
        if (i_trigger) begin
          next_st.wr_free[m] = 1'b0;
          next_st.wr_left[m] = WORDS - {1'b0, st.marker};
          if (split_now) begin
            next_st.wr_on[o]   = 1'b1;
            next_st.wr_free[o] = 1'b0;
            next_st.wr_addr[o] = '0;
            next_st.wr_left[o] = WORDS;
            next_st.tmr[o]     = '0;
          end else if (!dual) begin
            next_st.wr_free[o] = 1'b0;
            next_st.wr_left[o] = WORDS - {1'b0, st.marker};
          end
          next_st.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (st.other_pend && st.wr_on[m] && tick[m] && (st.wr_addr[m] == st.marker)) begin
          next_st.other_pend = 1'b0;
          next_st.wr_on[o]   = 1'b1;
          next_st.wr_free[o] = 1'b0;
          next_st.wr_addr[o] = '0;
          next_st.wr_left[o] = WORDS;
          next_st.tmr[o]     = '0;
        end
        if (i_early_capture && !split_now && dual && !next_st.wr_on[0]) begin
          next_st.wr_on[1] = 1'b0;
        end
        if (next_st.wr_on == 2'b00 && !next_st.other_pend) begin
          next_st.gtmr = '0;
          if (i_auto_repeat) begin
            next_st.state = ST_PREP;
          end else if (!i_early_capture && i_hold_time_en && (i_hold_secs != '0)) begin
            next_st.secs  = i_hold_secs;
            next_st.state = ST_HOLDOFF;
          end else begin
            next_st.state = ST_READ;
          end
        end
      end
      ST_HOLDOFF: begin
        if (st.gtmr >= TMR_W'(SEC_CYCLES - 1)) begin
          next_st.gtmr = '0;
          next_st.secs = st.secs - 1'b1;
          if (st.secs <= HOLD_W'(1)) begin
            next_st.state = ST_READ;
          end
        end else begin
          next_st.gtmr = st.gtmr + TMR_W'(1);
        end
      end
      ST_PREP: begin
        if (st.gtmr >= TMR_W'(PREP_CYCLES - 1)) begin
          next_st.gtmr     = '0;
          next_st.pen_addr = '0;
          next_st.state    = ST_PEN;
        end else begin
          next_st.gtmr = st.gtmr + TMR_W'(1);
        end
      end
      ST_PEN: begin
        if (st.gtmr >= pen_per - TMR_W'(1)) begin
          next_st.gtmr       = '0;
          next_st.rec_first  = st.mem[0][st.pen_addr];
          next_st.rec_second = st.mem[1][st.pen_addr];
          next_st.pen_addr   = st.pen_addr + 1'b1;
          if (st.pen_addr == ADDR_LAST) begin
            next_st.state = ST_READ;
          end
        end else begin
          next_st.gtmr = st.gtmr + TMR_W'(1);
        end
      end
      default: next_st.state = ST_READ;
    endcase

    // Marker movement: single step on press, repeat while held
    next_st.btn_prev = {i_marker_right, i_marker_left};
    if (i_marker_right ^ i_marker_left) begin
      if ((i_marker_right && !st.btn_prev[1]) || (i_marker_left && !st.btn_prev[0])) begin
        step            = 1'b1;
        next_st.btn_tmr = '0;
      end else if (st.btn_tmr >= TMR_W'(REPEAT_CYCLES - 1)) begin
        step            = 1'b1;
        next_st.btn_tmr = TMR_W'(REPEAT_CYCLES - STEP_CYCLES);
      end else begin
        next_st.btn_tmr = st.btn_tmr + TMR_W'(1);
      end
    end else begin
      next_st.btn_tmr = '0;
    end
    if (step && i_marker_right && (st.marker < MARK_MAX)) begin
      next_st.marker = st.marker + 1'b1;
    end else if (step && i_marker_left && (st.marker > MARK_MIN)) begin
      next_st.marker = st.marker - 1'b1;
    end

    if (xy || (!i_early_capture && (!i_split_channel || dual))) begin
      next_st.mark_show = 2'b00;
    end else begin
      next_st.mark_show = m ? 2'b10 : 2'b01;
    end

    // Display readout: free scan, or stepped by the external read clock
    next_st.ext_prev = i_external_read_clock;
    if (!i_ext_read_sel || (i_external_read_clock && !st.ext_prev)) begin
      next_st.disp_ptr = st.disp_ptr + 1'b1;
    end
    next_st.disp_addr   = st.disp_ptr;
    next_st.disp_first  = st.mem[0][st.disp_ptr];
    next_st.disp_second = st.mem[1][st.disp_ptr];
    next_st.disp_valid  = !((st.wr_on[0] && fast[0]) || (st.wr_on[1] && fast[1]));

    // Remote memory port and status
    if (i_remote_sel && i_wr && !i_addr[REM_STAT_BIT]) begin
      next_st.mem[i_addr[REM_MEM_BIT]][i_addr[ADDR_W-1:0]] = i_wdata;
    end
    next_st.rdata = '0;
    if (i_rd && i_addr[REM_STAT_BIT]) begin
      next_st.rdata = {st.wr_on, st.other_pend, 2'h0, st.state};
    end else if (i_rd && i_remote_sel) begin
      next_st.rdata = st.mem[i_addr[REM_MEM_BIT]][i_addr[ADDR_W-1:0]];
    end

    next_st.led_write  = next_st.wr_on;
    next_st.led_read   = (next_st.wr_on == 2'b00);
    next_st.led_hold   = (|i_hold_memory) || i_ext_read_sel;
    next_st.rec_active = (next_st.state == ST_PEN);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st          <= '0;
      st.marker   <= MARK_MIN;
      st.led_read <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata       = st.rdata;
  assign o_write_led   = st.led_write;
  assign o_read_led    = st.led_read;
  assign o_hold_led    = st.led_hold;
  assign o_marker      = st.marker;
  assign o_marker_show = st.mark_show;
  assign o_disp_addr   = st.disp_addr;
  assign o_disp_first  = st.disp_first;
  assign o_disp_second = st.disp_second;
  assign o_disp_valid  = st.disp_valid;
  assign o_rec_first   = st.rec_first;
  assign o_rec_second  = st.rec_second;
  assign o_rec_active  = st.rec_active;
endmodule : waveform_capture_sequencer

// ==== verification/wcs_panel_model.sv ====
// Front panel and trigger comparator model facing the sequencer.
// Assumes requests from the bench arrive as one-cycle levels on i_ref_clk.
`timescale 1ns/1ps
module wcs_panel_model (
  input  wire logic i_ref_clk,
  input  wire logic i_arst_n,
  input  wire logic i_trig_req,
  input  wire logic i_start_req,
  input  wire logic i_rec_want,
  input  wire logic i_read_led,
  output logic      o_trigger,
  output logic      o_start,
  output logic      o_recorder_mode
);
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_trigger       <= 1'b0;
      o_start         <= 1'b0;
      o_recorder_mode <= 1'b0;
    end else begin
      o_trigger <= i_trig_req && !o_trigger;
      o_start   <= i_start_req && !o_start;
      // Recorder mode only changes while no write runs
      if (i_read_led) begin
        o_recorder_mode <= i_rec_want;
      end
    end
  end
endmodule : wcs_panel_model

// ==== verification/wcs_props.sv ====
// Port checker for the capture sequencer.
// Assumes one clock domain and the design's asynchronous reset.
`timescale 1ns/1ps
module wcs_props #(
  parameter int PREP_CYCLES = 20
) (
  input wire logic                         i_ref_clk,
  input wire logic                         i_arst_n,
  input wire logic                         i_trigger,
  input wire logic                         i_start,
  input wire logic                         i_early_capture,
  input wire logic                         i_split_channel,
  input wire logic [2:0]                   i_trace_sel,
  input wire logic [wcs_pkg::RATE_W-1:0]   i_rate_a,
  input wire logic [wcs_pkg::RATE_W-1:0]   i_rate_b,
  input wire logic                         i_ext_read_sel,
  input wire logic                         i_remote_sel,
  input wire logic [1:0]                   i_hold_memory,
  input wire logic                         i_marker_left,
  input wire logic                         i_marker_right,
  input wire logic                         i_recorder_mode,
  input wire logic                         i_auto_repeat,
  input wire logic                         i_hold_time_en,
  input wire logic [wcs_pkg::REM_AW-1:0]   i_addr,
  input wire logic                         i_rd,
  input wire logic [wcs_pkg::DATA_W-1:0]   o_rdata,
  input wire logic [1:0]                   o_write_led,
  input wire logic                         o_read_led,
  input wire logic                         o_hold_led,
  input wire logic [wcs_pkg::ADDR_W-1:0]   o_marker,
  input wire logic [1:0]                   o_marker_show,
  input wire logic                         o_disp_valid,
  input wire logic                         o_rec_active
);
  import wcs_pkg::*;
  localparam int PREP_LIM = PREP_CYCLES + 4;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_ss_go;
    i_trigger && o_read_led && !i_early_capture && !i_split_channel && !i_ext_read_sel
      && !i_recorder_mode && !i_auto_repeat && !i_hold_time_en;
  endsequence
  sequence s_rec_go;
    i_start && i_recorder_mode && o_read_led && !i_ext_read_sel && !o_rec_active;
  endsequence

  property p_ss_start;
    s_ss_go |=> o_write_led == 2'b11 && !o_read_led;
  endproperty
  property p_ext_block;
    i_ext_read_sel && o_read_led |=> o_write_led == 2'b00;
  endproperty
  property p_hold_lamp;
    (i_ext_read_sel || (|i_hold_memory)) |=> o_hold_led;
  endproperty
  property p_mark_range;
    o_marker >= MARK_MIN && o_marker <= MARK_MAX;
  endproperty
  property p_mark_step;
    $rose(i_marker_right) && !i_marker_left && o_marker < MARK_MAX
      |=> o_marker == $past(o_marker) + 11'h001;
  endproperty
  property p_mark_hide;
    ((!i_early_capture && !i_split_channel) || i_trace_sel == 3'h4) |=> o_marker_show == 2'b00;
  endproperty
  property p_fast_hide;
    $past(o_write_led) == 2'b11 && o_write_led == 2'b11 && i_rate_a < FAST_RATES
      && i_rate_b < FAST_RATES |-> !o_disp_valid;
  endproperty
  property p_rd_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  property p_rd_refuse;
    i_rd && !i_addr[REM_STAT_BIT] && !i_remote_sel |=> o_rdata == 8'h00;
  endproperty
  property p_rec_prep;
    s_rec_go |=> !o_rec_active [*8];
  endproperty
  property p_rec_begin;
    s_rec_go |-> ##[1:PREP_LIM] o_rec_active;
  endproperty

  a_ss_start:   assert property (p_ss_start)   else $error("write did not start");
  a_ext_block:  assert property (p_ext_block)  else $error("write under ext read");
  a_hold_lamp:  assert property (p_hold_lamp)  else $error("hold lamp dark");
  a_mark_range: assert property (p_mark_range) else $error("marker out of range");
  a_mark_step:  assert property (p_mark_step)  else $error("marker step wrong");
  a_mark_hide:  assert property (p_mark_hide)  else $error("marker shown");
  a_fast_hide:  assert property (p_fast_hide)  else $error("display during fast write");
  a_rd_idle:    assert property (p_rd_idle)    else $error("read data not cleared");
  a_rd_refuse:  assert property (p_rd_refuse)  else $error("remote read not refused");
  a_rec_prep:   assert property (p_rec_prep)   else $error("recorder began early");
  a_rec_begin:  assert property (p_rec_begin)  else $error("recorder never began");
endmodule : wcs_props

bind waveform_capture_sequencer wcs_props #(.PREP_CYCLES(PREP_CYCLES)) i_props (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_trigger(i_trigger), .i_start(i_start),
  .i_early_capture(i_early_capture), .i_split_channel(i_split_channel),
  .i_trace_sel(i_trace_sel), .i_rate_a(i_rate_a), .i_rate_b(i_rate_b),
  .i_ext_read_sel(i_ext_read_sel), .i_remote_sel(i_remote_sel), .i_hold_memory(i_hold_memory),
  .i_marker_left(i_marker_left), .i_marker_right(i_marker_right),
  .i_recorder_mode(i_recorder_mode), .i_auto_repeat(i_auto_repeat),
  .i_hold_time_en(i_hold_time_en), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_write_led(o_write_led), .o_read_led(o_read_led), .o_hold_led(o_hold_led),
  .o_marker(o_marker), .o_marker_show(o_marker_show), .o_disp_valid(o_disp_valid),
  .o_rec_active(o_rec_active));

// ==== verification/tb_waveform_capture_sequencer.sv ====
// Self-checking bench for the capture sequencer.
// Assumes shortened timing parameters; panel model drives trigger and start.
`timescale 1ns/1ps
module tb_waveform_capture_sequencer;
  import wcs_pkg::*;
  logic              i_ref_clk = 1'b0;
  logic              i_arst_n = 1'b0;
  logic [DATA_W-1:0] i_first_input = 8'h5A, i_second_input = 8'hA5, i_wdata = 8'h00;
  logic              i_early_capture = 1'b0, i_split_channel = 1'b0, i_ext_read_sel = 1'b0;
  logic              i_external_read_clock = 1'b0, i_remote_sel = 1'b1, i_auto_repeat = 1'b0;
  logic              i_marker_left = 1'b0, i_marker_right = 1'b0, i_hold_time_en = 1'b0;
  logic              i_wr = 1'b0, i_rd = 1'b0, trig_req = 1'b0, start_req = 1'b0, rec_want = 1'b0;
  logic [2:0]        i_trace_sel = 3'h0;
  logic [RATE_W-1:0] i_rate_a = 4'h0, i_rate_b = 4'h0;
  logic [1:0]        i_hold_memory = 2'h0, i_pen_speed = 2'h0, o_write_led, o_marker_show;
  logic [HOLD_W-1:0] i_hold_secs = 5'h00;
  logic [REM_AW-1:0] i_addr = 13'h0000;
  logic              i_trigger, i_start, i_recorder_mode, o_read_led, o_hold_led;
  logic              o_disp_valid, o_rec_active;
  logic [DATA_W-1:0] o_rdata, o_disp_first, o_disp_second, o_rec_first, o_rec_second;
  logic [ADDR_W-1:0] o_marker, o_disp_addr;
  int                n_errors = 0, checks = 0, n;

  always #50 i_ref_clk = ~i_ref_clk;

  wcs_panel_model i_panel (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_trig_req(trig_req),
    .i_start_req(start_req), .i_rec_want(rec_want), .i_read_led(o_read_led),
    .o_trigger(i_trigger), .o_start(i_start), .o_recorder_mode(i_recorder_mode));

  waveform_capture_sequencer #(.CYC_PER_US(1), .CYC_PER_MS(4), .PREP_CYCLES(20),
    .REPEAT_CYCLES(8), .STEP_CYCLES(2)) i_dut (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_first_input(i_first_input),
    .i_second_input(i_second_input), .i_trigger(i_trigger), .i_start(i_start),
    .i_early_capture(i_early_capture), .i_split_channel(i_split_channel),
    .i_trace_sel(i_trace_sel), .i_rate_a(i_rate_a), .i_rate_b(i_rate_b),
    .i_ext_read_sel(i_ext_read_sel), .i_external_read_clock(i_external_read_clock),
    .i_remote_sel(i_remote_sel), .i_hold_memory(i_hold_memory),
    .i_marker_left(i_marker_left), .i_marker_right(i_marker_right),
    .i_recorder_mode(i_recorder_mode), .i_auto_repeat(i_auto_repeat),
    .i_pen_speed(i_pen_speed), .i_hold_time_en(i_hold_time_en), .i_hold_secs(i_hold_secs),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_write_led(o_write_led), .o_read_led(o_read_led), .o_hold_led(o_hold_led),
    .o_marker(o_marker), .o_marker_show(o_marker_show), .o_disp_addr(o_disp_addr),
    .o_disp_first(o_disp_first), .o_disp_second(o_disp_second),
    .o_disp_valid(o_disp_valid), .o_rec_first(o_rec_first), .o_rec_second(o_rec_second),
    .o_rec_active(o_rec_active));

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask : tick

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [REM_AW-1:0] a, input logic [DATA_W-1:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_rdata, exp);
    @(posedge i_ref_clk);
  endtask : rd_chk

  task automatic wr(input logic [REM_AW-1:0] a, input logic [DATA_W-1:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Request a one-cycle trigger (1) or start (0); ends on the falling edge after the edge the design takes it
  task automatic fire(input logic trig);
    if (trig) trig_req <= 1'b1;
    else start_req <= 1'b1;
    @(posedge i_ref_clk);
    trig_req <= 1'b0;
    start_req <= 1'b0;
    tick(1);
    @(negedge i_ref_clk);
  endtask : fire

  task automatic wait_idle();
    n = 0;
    while (o_read_led !== 1'b1 && n < 5000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 5000) begin
      n_errors++;
      report_and_stop();
    end
    @(posedge i_ref_clk);
  endtask : wait_idle

  initial begin
    tick(3);
    i_arst_n <= 1'b1;
    @(negedge i_ref_clk);
    chk(o_read_led, 16'h1);
    chk(o_marker, 16'h002);
    @(posedge i_ref_clk);
    fire(1'b1);
    chk(o_write_led, 16'h3);
    chk(o_read_led, 16'h0);
    @(posedge i_ref_clk);
    rd_chk(13'h1000, 8'hC2);
    wait_idle();
    chk({15'h0, n >= 2040 && n <= 2052}, 16'h1);
    rd_chk(13'h0005, 8'h5A);
    rd_chk(13'h0805, 8'hA5);
    i_hold_memory <= 2'b01;
    i_hold_time_en <= 1'b1;
    i_hold_secs <= 5'h01;
    i_first_input <= 8'h33;
    i_second_input <= 8'h3C;
    fire(1'b1);
    chk(o_write_led, 16'h3);
    chk(o_hold_led, 16'h1);
    @(posedge i_ref_clk);
    wait_idle();
    i_hold_memory <= 2'b00;
    rd_chk(13'h0007, 8'h5A);
    rd_chk(13'h0807, 8'h3C);
    fire(1'b1);
    chk(o_write_led, 16'h0);
    tick(4000);
    i_hold_time_en <= 1'b0;
    wr(13'h0009, 8'hC3);
    rd_chk(13'h0009, 8'hC3);
    i_remote_sel <= 1'b0;
    rd_chk(13'h0009, 8'h00);
    i_remote_sel <= 1'b1;
    i_ext_read_sel <= 1'b1;
    fire(1'b1);
    chk(o_write_led, 16'h0);
    chk(o_hold_led, 16'h1);
    chk(o_disp_second, 16'h3C);
    n = o_disp_addr;
    tick(3);
    chk(o_disp_addr, n);
    i_external_read_clock <= 1'b1;
    tick(3);
    chk(o_disp_addr, (n + 1) % MEM_DEPTH);
    @(posedge i_ref_clk);
    i_ext_read_sel <= 1'b0;
    i_marker_left <= 1'b1;
    tick(1);
    i_marker_left <= 1'b0;
    tick(2);
    chk(o_marker, 16'h002);
    i_marker_right <= 1'b1;
    tick(1);
    i_marker_right <= 1'b0;
    tick(2);
    chk(o_marker, 16'h003);
    i_marker_right <= 1'b1;
    tick(4500);
    i_marker_right <= 1'b0;
    tick(2);
    chk(o_marker, 16'h7D0);
    i_early_capture <= 1'b1;
    tick(2);
    chk(o_marker_show, 16'h1);
    i_trace_sel <= 3'h3;
    tick(2);
    chk(o_marker_show, 16'h2);
    i_trace_sel <= 3'h0;
    fire(1'b0);
    chk(o_write_led, 16'h3);
    tick(100);
    fire(1'b1);
    @(posedge i_ref_clk);
    wait_idle();
    chk({15'h0, n >= 44 && n <= 50}, 16'h1);
    i_early_capture <= 1'b0;
    rec_want <= 1'b1;
    tick(3);
    fire(1'b0);
    tick(14);
    chk(o_rec_active, 16'h0);
    tick(10);
    chk(o_rec_active, 16'h1);
    tick(40);
    chk(o_rec_first, 16'h33);
    chk(o_rec_second, 16'h3C);
    i_arst_n <= 1'b0;
    rec_want <= 1'b0;
    tick(2);
    i_arst_n <= 1'b1;
    @(negedge i_ref_clk);
    chk(o_rec_active, 16'h0);
    chk(o_read_led, 16'h1);
    report_and_stop();
  end
endmodule : tb_waveform_capture_sequencer
